// ===== rtl/codec_rate_and_path_control.sv
// Rate generation, clip interrupts and path control of an audio and telecom codec.
// Assumes all inputs are synchronous to sys_clk except clip_detect, which is synchronised here.
`timescale 1ns/100ps

module codec_rate_and_path_control
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_bus_clock,
    input wire logic [codec_ctrl_pkg::DIV_W-1:0] audio_rate_divisor,
    input wire logic [codec_ctrl_pkg::DIV_W-1:0] telecom_rate_divisor,
    input wire codec_ctrl_pkg::audio_ctrl_t audio_ctrl,
    input wire codec_ctrl_pkg::tel_ctrl_t telecom_ctrl,
    input wire logic [codec_ctrl_pkg::GAIN_W-1:0] audio_gain,
    input wire logic offset_cancel_disable,
    input wire logic clip_detect,
    input wire logic overload_rise_irq_enable,
    input wire logic overload_fall_irq_enable,
    input wire logic [codec_ctrl_pkg::SAMPLE_W-1:0] play_data,
    input wire logic play_valid,
    input wire logic [codec_ctrl_pkg::SAMPLE_W-1:0] mic_sample,
    input wire logic [codec_ctrl_pkg::SAMPLE_W-1:0] line_sample,
    input wire logic [codec_ctrl_pkg::SAMPLE_W-1:0] tel_play_data,
    output logic play_ready,
    output logic [codec_ctrl_pkg::SAMPLE_W-1:0] audio_cap_data,
    output logic audio_cap_valid,
    output logic [codec_ctrl_pkg::SAMPLE_W-1:0] tel_cap_data,
    output logic tel_cap_valid,
    output logic audio_sample_tick,
    output logic telecom_sample_tick,
    output logic [1:0] rate_fault,
    output logic [codec_ctrl_pkg::DAC_W-1:0] speaker_code,
    output logic speaker_drive_enable,
    output logic [codec_ctrl_pkg::DAC_W-1:0] line_code,
    output logic line_drive_enable,
    output logic [codec_ctrl_pkg::ANALOG_W-1:0] analog_atten_step,
    output logic [codec_ctrl_pkg::GAIN_W-1:0] mic_gain_step,
    output logic offset_cancel_enable,
    output logic capture_path_on,
    output logic mic_return_switch_out,
    output logic mic_return_switch_oe_n,
    output logic voice_filter_on,
    output logic audio_overload_flag,
    output logic interrupt_output
);
    import codec_ctrl_pkg::*;

    // Whole state of the block.
    typedef struct packed {
        logic bus_clk;
        logic clip_meta;
        logic clip_sync;
        logic clip_prev;
        logic [NCH-1:0][DIV_W-1:0] edge_cnt;
        logic [NCH-1:0][OSR_W-1:0] phase;
        logic [NCH-1:0] osr_tick;
        logic [NCH-1:0] sample_tick;
        logic [NCH-1:0] fault;
        logic irq;
        logic [1:0][SAMPLE_W-1:0] fifo;
        logic head;
        logic [1:0] count;
        logic ready;
        logic [SAMPLE_W-1:0] play_word;
        logic [SAMPLE_W-1:0] tel_word;
        logic [NCH-1:0][RES_W-1:0] residue;
        logic [NCH-1:0][DAC_W-1:0] code;
        logic [SAMPLE_W-1:0] aud_cap;
        logic aud_cap_valid;
        logic [SAMPLE_W-1:0] tel_cap;
        logic tel_cap_valid;
        logic spk_en;
        logic [ANALOG_W-1:0] analog_step;
        logic [GAIN_W-1:0] gain;
        logic ofs_en;
        logic cap_on;
        logic mic_oe_n;
        logic voice_on;
        logic overload;
        logic line_on;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [ATTEN_W-1:0] atten_clamped;
    logic [SAMPLE_W-1:0] atten_word;
    logic [SAMPLE_W-1:0] spk_word;
    logic [SAMPLE_W-1:0] line_word;

    // Attenuation split: low three code bits go to the analog stage, the rest pick a digital shift.
    always_comb
    begin
        atten_clamped = (audio_ctrl.atten > ATTEN_MAX) ? ATTEN_MAX : audio_ctrl.atten;
        unique case (atten_clamped[ATTEN_W-1:ANALOG_W])
            2'h0: atten_word = s_q.play_word;
            2'h1: atten_word = $signed(s_q.play_word) >>> DIG_SHIFT_24DB;
            default: atten_word = $signed(s_q.play_word) >>> DIG_SHIFT_48DB;
        endcase
        spk_word = audio_ctrl.mute ? '0 : atten_word;
        line_word = telecom_ctrl.line_output_silence ? '0 : s_q.tel_word;
    end

    // Next state of every register.
    always_comb
    begin
        logic [DIV_W-1:0] div;
        logic [DIV_W-1:0] target;
        logic step;
        logic rise;
        logic any_edge;
        logic clip_rise;
        logic clip_fall;
        logic push;
        logic pop;
        logic [SAMPLE_W:0] sum;
        logic [SAMPLE_W-1:0] x;
        div = '0;
        target = '0;
        step = 1'b0;
        rise = 1'b0;
        any_edge = 1'b0;
        clip_rise = 1'b0;
        clip_fall = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        sum = '0;
        x = '0;
        s_d = s_q;
        s_d.osr_tick = '0;
        s_d.sample_tick = '0;
        s_d.aud_cap_valid = 1'b0;
        s_d.tel_cap_valid = 1'b0;

        // Bus clock edges seen against the previous sample.
        s_d.bus_clk = serial_bus_clock;
        rise = serial_bus_clock && !s_q.bus_clk;
        any_edge = serial_bus_clock != s_q.bus_clk;

        // Rate generators: an odd divisor counts both edges, an even one counts half as many rising edges.
        for (int ch = 0; ch < NCH; ch++)
        begin
            div = (ch == CH_AUD) ? audio_rate_divisor : telecom_rate_divisor;
            s_d.fault[ch] = div <= ((ch == CH_AUD) ? AUD_DIV_LOW : TEL_DIV_LOW);
            step = div[0] ? any_edge : rise;
            target = div[0] ? div : {1'b0, div[DIV_W-1:1]};
            if (s_d.fault[ch])
            begin
                s_d.edge_cnt[ch] = '0;
                s_d.phase[ch] = '0;
            end
            else if (step)
            begin
                if (s_q.edge_cnt[ch] == target - 7'h01)
                begin
                    s_d.edge_cnt[ch] = '0;
                    s_d.osr_tick[ch] = 1'b1;
                    s_d.phase[ch] = s_q.phase[ch] + 6'h01;
                    s_d.sample_tick[ch] = s_q.phase[ch] == OSR_LAST;
                end
                else
                begin
                    s_d.edge_cnt[ch] = s_q.edge_cnt[ch] + 7'h01;
                end
            end

            // First-order modulator: 4-bit code plus carried residue on each oversampling tick.
            x = ((ch == CH_AUD) ? spk_word : line_word) ^ SIGN_FLIP;
            if (s_q.osr_tick[ch])
            begin
                sum = {1'b0, x} + {5'h00, s_q.residue[ch]};
                if (sum[SAMPLE_W])
                begin
                    s_d.code[ch] = '1;
                    s_d.residue[ch] = '1;
                end
                else
                begin
                    s_d.code[ch] = sum[SAMPLE_W-1:RES_W];
                    s_d.residue[ch] = sum[RES_W-1:0];
                end
            end
        end

        // Playback buffer: two entries, ready drops only when both hold a word.
        push = play_valid && s_q.ready;
        pop = s_q.sample_tick[CH_AUD] && (s_q.count != 2'h0);
        if (push)
        begin
            s_d.fifo[s_q.head ^ s_q.count[0]] = play_data;
        end
        if (pop)
        begin
            s_d.play_word = audio_ctrl.playback_en ? s_q.fifo[s_q.head] : '0;
            s_d.head = !s_q.head;
        end
        s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
        s_d.ready = s_d.count != BUF_FULL;

        // Audio capture: loopback takes the playback word and ignores the microphone.
        if (s_q.sample_tick[CH_AUD] && audio_ctrl.capture_en)
        begin
            s_d.aud_cap = audio_ctrl.loopback ? atten_word : mic_sample;
            s_d.aud_cap_valid = 1'b1;
        end

        // Telecom sample exchange; loopback puts the output path in series with the input.
        if (s_q.sample_tick[CH_TEL])
        begin
            s_d.tel_word = tel_play_data;
            s_d.tel_cap = telecom_ctrl.loopback ? s_q.tel_word : line_sample;
            s_d.tel_cap_valid = 1'b1;
        end

        // Clip detect: two-stage synchroniser, then edges taken from the settled stages.
        s_d.clip_meta = clip_detect;
        s_d.clip_sync = s_q.clip_meta;
        s_d.clip_prev = s_q.clip_sync;
        clip_rise = s_q.clip_sync && !s_q.clip_prev;
        clip_fall = !s_q.clip_sync && s_q.clip_prev;
        s_d.overload = s_q.clip_sync;
        s_d.irq = (clip_rise && overload_rise_irq_enable) || (clip_fall && overload_fall_irq_enable);

        // Analog controls, registered toward the pins.
        s_d.analog_step = atten_clamped[ANALOG_W-1:0];
        s_d.spk_en = audio_ctrl.playback_en;
        s_d.gain = audio_gain;
        s_d.ofs_en = !offset_cancel_disable;
        s_d.cap_on = audio_ctrl.capture_en;
        s_d.mic_oe_n = !audio_ctrl.capture_en;
        s_d.voice_on = telecom_ctrl.voiceband_filter_enable;
        s_d.line_on = 1'b1;
    end

    // State register.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.mic_oe_n <= 1'b1;
            s_q.ofs_en <= 1'b1;
            s_q.fault <= '1;
            s_q.line_on <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register; mic_return_switch_out is tied low.
    assign play_ready = s_q.ready;
    assign audio_cap_data = s_q.aud_cap;
    assign audio_cap_valid = s_q.aud_cap_valid;
    assign tel_cap_data = s_q.tel_cap;
    assign tel_cap_valid = s_q.tel_cap_valid;
    assign audio_sample_tick = s_q.sample_tick[CH_AUD];
    assign telecom_sample_tick = s_q.sample_tick[CH_TEL];
    assign rate_fault = s_q.fault;
    assign speaker_code = s_q.code[CH_AUD];
    assign speaker_drive_enable = s_q.spk_en;
    assign line_code = s_q.code[CH_TEL];
    assign line_drive_enable = s_q.line_on;
    assign analog_atten_step = s_q.analog_step;
    assign mic_gain_step = s_q.gain;
    assign offset_cancel_enable = s_q.ofs_en;
    assign capture_path_on = s_q.cap_on;
    assign mic_return_switch_out = 1'b0;
    assign mic_return_switch_oe_n = s_q.mic_oe_n;
    assign voice_filter_on = s_q.voice_on;
    assign audio_overload_flag = s_q.overload;
    assign interrupt_output = s_q.irq;

    // Checks on the design's own outputs and its playback buffer count.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence clip_rise_s;
        s_q.clip_sync && !s_q.clip_prev;
    endsequence

    sequence clip_fall_s;
        !s_q.clip_sync && s_q.clip_prev;
    endsequence

    chk_irq_rise_edge: assert property (clip_rise_s ##0 overload_rise_irq_enable |=> interrupt_output)
        else $error("rising clip edge gave no interrupt");
    chk_irq_fall_edge: assert property (clip_fall_s ##0 overload_fall_irq_enable |=> interrupt_output)
        else $error("falling clip edge gave no interrupt");
    chk_irq_single_event: assert property (interrupt_output |=> !interrupt_output)
        else $error("one clip transition gave two interrupt cycles");
    chk_clip_sync_path: assert property (clip_detect ##1 clip_detect ##1 clip_detect |=> audio_overload_flag)
        else $error("overload flag missed a held clip");
    chk_mic_return_float: assert property (!audio_ctrl.capture_en |=> mic_return_switch_oe_n)
        else $error("microphone return driven while capture is off");
    chk_mute_speaker_silent: assert property (audio_ctrl.mute && s_q.osr_tick[CH_AUD] |=> speaker_code == 4'h8)
        else $error("muted speaker produced a signal");
    chk_mute_driver_on: assert property (audio_ctrl.mute && audio_ctrl.playback_en |=> speaker_drive_enable)
        else $error("mute switched the speaker driver off");
    chk_loop_capture_word: assert property (audio_ctrl.loopback && audio_ctrl.capture_en
        && audio_sample_tick |=> audio_cap_valid && audio_cap_data == $past(atten_word))
        else $error("loopback capture did not take the playback word");
    chk_audio_div_range: assert property (audio_rate_divisor <= AUD_DIV_LOW |=> rate_fault[CH_AUD]
        ##1 !audio_sample_tick)
        else $error("illegal audio divisor not refused");
    chk_tel_div_range: assert property (telecom_rate_divisor <= TEL_DIV_LOW |=> rate_fault[CH_TEL])
        else $error("illegal telecom divisor not refused");
    chk_analog_atten_split: assert property (audio_ctrl.atten <= ATTEN_MAX
        |=> analog_atten_step == $past(audio_ctrl.atten[2:0]))
        else $error("analog attenuation step wrong");
    chk_offset_cancel_off: assert property (offset_cancel_disable |=> !offset_cancel_enable)
        else $error("offset cancellation stayed on");
    chk_voice_filter_follow: assert property (##1 voice_filter_on == $past(telecom_ctrl.voiceband_filter_enable))
        else $error("voice filter does not follow its enable");
    chk_buffer_push_count: assert property (play_valid && play_ready && !(audio_sample_tick && s_q.count != 2'h0)
        |=> s_q.count == $past(s_q.count) + 2'h1)
        else $error("accepted playback word not counted in the buffer");

endmodule // codec_rate_and_path_control

// ===== rtl/codec_ctrl_pkg.sv
// Constants and carrier types for the codec rate and path control block.
// Assumes one system clock; the serial bus clock is sampled as a plain input.
package codec_ctrl_pkg;

    // Divisor fields and their exclusive lower bounds; 7-bit fields stay below 128.
    localparam int DIV_W = 7;
    localparam logic [6:0] AUD_DIV_LOW = 7'h07;
    localparam logic [6:0] TEL_DIV_LOW = 7'h0f;

    // Oversampling ratio of both converters and width of the phase count.
    localparam int OSR_W = 6;
    localparam logic [5:0] OSR_LAST = 6'h3f;

    // Sample words are two's complement, left justified in this width.
    localparam int SAMPLE_W = 16;
    localparam int DAC_W = 4;
    localparam int RES_W = SAMPLE_W - DAC_W;
    localparam logic [15:0] SIGN_FLIP = 16'h8000;

    // Output attenuation: 3 dB per code, 24 codes from 0 to 23 reach 69 dB.
    localparam int ATTEN_W = 5;
    localparam logic [4:0] ATTEN_MAX = 5'h17;
    localparam int ANALOG_W = 3;
    localparam int DIG_SHIFT_24DB = 4;
    localparam int DIG_SHIFT_48DB = 8;

    // Microphone gain code, 1.5 dB per step.
    localparam int GAIN_W = 5;

    // Channel indices of the rate generators and modulators.
    localparam int NCH = 2;
    localparam int CH_AUD = 0;
    localparam int CH_TEL = 1;

    // Playback buffer depth.
    localparam logic [1:0] BUF_FULL = 2'h2;

    // Audio path controls.
    typedef struct packed {
        logic [ATTEN_W-1:0] atten;
        logic mute;
        logic capture_en;
        logic playback_en;
        logic loopback;
    } audio_ctrl_t;

    // Telecom path controls.
    typedef struct packed {
        logic line_output_silence;
        logic loopback;
        logic voiceband_filter_enable;
    } tel_ctrl_t;

endpackage

// ===== testbench/serial_controller_model.sv
// Behavioural system controller: makes the serial bus clock and feeds the playback stream.
// Assumes its half period, in sys_clk cycles, is two or more, so sys_clk can sample it.
`timescale 1ns/100ps

module serial_controller_model
#(
    parameter int HALF = 2
)
(
    input wire logic sys_clk,
    input wire logic stream_on,
    input wire logic slow,
    input wire logic [15:0] word,
    input wire logic play_ready,
    output logic serial_bus_clock,
    output logic [15:0] play_data,
    output logic play_valid
);
    int n_half = 0;
    int n_cyc = 0;
    logic took = 1'b0;
    logic go = 1'b0;

    initial
    begin
        serial_bus_clock = 1'b0;
        play_valid = 1'b0;
        play_data = 16'h0000;
    end

    // Equal high and low spans keep sampling on both edges equidistant.
    always @(negedge sys_clk)
    begin
        n_half = n_half + 1;
        if (n_half == HALF)
        begin
            n_half = 0;
            serial_bus_clock <= ~serial_bus_clock;
        end
    end

    // A word is taken at the edge where ready is high.
    always @(posedge sys_clk)
        took = play_valid && play_ready;

    // A word stands until taken; a released data bus shows a changing pattern.
    always @(negedge sys_clk)
    begin
        n_cyc = n_cyc + 1;
        go = stream_on && (!slow || n_cyc % 3 == 0);
        if (!play_valid || took)
        begin
            play_valid <= go;
            play_data <= go ? word : ~play_data;
        end
    end
endmodule // serial_controller_model

// ===== testbench/test_codec_rate_and_path_control.sv
// Self-checking bench for the codec rate and path control block.
// Assumes the controller model makes the bus clock; all other inputs change at the falling edge.
`timescale 1ns/100ps

module test_codec_rate_and_path_control;
    import codec_ctrl_pkg::*;
    localparam int HALF = 2;
    logic sys_clk = 1'b0, rst = 1'b1, serial_bus_clock, play_valid, play_ready, stream_on = 1'b0, slow = 1'b0;
    logic [6:0] audio_rate_divisor = 7'h08, telecom_rate_divisor = 7'h10;
    audio_ctrl_t audio_ctrl = '0;
    tel_ctrl_t telecom_ctrl = '0;
    logic [4:0] audio_gain = 5'h00, mic_gain_step;
    logic offset_cancel_disable = 1'b0, clip_detect = 1'b0;
    logic overload_rise_irq_enable = 1'b0, overload_fall_irq_enable = 1'b0;
    logic [15:0] play_data, word = 16'h3000, mic_sample = 16'h0000, line_sample = 16'h0000, tel_play_data = 16'h0000;
    logic [15:0] audio_cap_data, tel_cap_data;
    logic audio_cap_valid, tel_cap_valid, audio_sample_tick, telecom_sample_tick, speaker_drive_enable;
    logic line_drive_enable, offset_cancel_enable, capture_path_on, mic_return_switch_out, mic_return_switch_oe_n;
    logic voice_filter_on, audio_overload_flag, interrupt_output;
    logic [1:0] rate_fault;
    logic [3:0] speaker_code, line_code;
    logic [2:0] analog_atten_step;
    logic [6:0] ev;
    logic [31:0] seed = 32'h00000054;
    int n_mismatch = 0, n_tests = 0, cyc = 0, n, t0, t1;

    // Events watched by the counting and waiting tasks.
    assign ev = {line_code !== 4'h8, speaker_code !== 4'h8, interrupt_output, tel_cap_valid, audio_cap_valid,
        telecom_sample_tick, audio_sample_tick};

    codec_rate_and_path_control i_dut (.sys_clk(sys_clk), .rst(rst), .serial_bus_clock(serial_bus_clock),
        .audio_rate_divisor(audio_rate_divisor), .telecom_rate_divisor(telecom_rate_divisor),
        .audio_ctrl(audio_ctrl), .telecom_ctrl(telecom_ctrl), .audio_gain(audio_gain),
        .offset_cancel_disable(offset_cancel_disable), .clip_detect(clip_detect),
        .overload_rise_irq_enable(overload_rise_irq_enable), .overload_fall_irq_enable(overload_fall_irq_enable),
        .play_data(play_data), .play_valid(play_valid), .mic_sample(mic_sample), .line_sample(line_sample),
        .tel_play_data(tel_play_data), .play_ready(play_ready), .audio_cap_data(audio_cap_data),
        .audio_cap_valid(audio_cap_valid), .tel_cap_data(tel_cap_data), .tel_cap_valid(tel_cap_valid),
        .audio_sample_tick(audio_sample_tick), .telecom_sample_tick(telecom_sample_tick),
        .rate_fault(rate_fault), .speaker_code(speaker_code), .speaker_drive_enable(speaker_drive_enable),
        .line_code(line_code), .line_drive_enable(line_drive_enable), .analog_atten_step(analog_atten_step),
        .mic_gain_step(mic_gain_step), .offset_cancel_enable(offset_cancel_enable),
        .capture_path_on(capture_path_on), .mic_return_switch_out(mic_return_switch_out),
        .mic_return_switch_oe_n(mic_return_switch_oe_n), .voice_filter_on(voice_filter_on),
        .audio_overload_flag(audio_overload_flag), .interrupt_output(interrupt_output));

    serial_controller_model #(.HALF(HALF)) i_ctrl (.sys_clk(sys_clk), .stream_on(stream_on), .slow(slow),
        .word(word), .play_ready(play_ready), .serial_bus_clock(serial_bus_clock), .play_data(play_data),
        .play_valid(play_valid));

    // Clock and cycle count.
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        cyc++;

    // Xorshift source of random stimulus.
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected cycles between sample ticks: 64 osr ticks of one divisor of bus edges.
    function automatic int tick_period(input int d);
        return 64 * d * HALF;
    endfunction

    // Analog part of the attenuation after clamping to the largest code.
    function automatic logic [2:0] analog_exp(input logic [4:0] code);
        return (code > ATTEN_MAX) ? 3'h7 : code[2:0];
    endfunction

    // Digital part of the attenuation applied to the looped word.
    function automatic logic [15:0] atten_exp(input logic [15:0] w, input logic [4:0] code);
        if (code >= 5'h10)
            return $signed(w) >>> 8;
        if (code >= 5'h08)
            return $signed(w) >>> 4;
        return w;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Waits for the next event of one kind, bounded, and notes the cycle.
    task automatic wait_ev(input int sel, output int at);
        int k;
        k = 0;
        @(negedge sys_clk);
        while (ev[sel] !== 1'b1 && k < 20000)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 20000)
            check(16'h0001, 16'h0000);
        at = cyc;
    endtask

    // Counts cycles with an event over a span.
    task automatic count_ev(input int sel, input int span, output int cnt);
        cnt = 0;
        repeat (span)
        begin
            @(negedge sys_clk);
            cnt += (ev[sel] === 1'b1);
        end
    endtask

    task automatic measure(input int da, input int dt);
        audio_rate_divisor = da[6:0];
        telecom_rate_divisor = dt[6:0];
        wait_ev(0, t0);
        wait_ev(0, t0);
        wait_ev(0, t1);
        check(16'(t1 - t0), 16'(tick_period(da)));
        wait_ev(1, t0);
        wait_ev(1, t0);
        wait_ev(1, t1);
        check(16'(t1 - t0), 16'(tick_period(dt)));
    endtask

    task automatic done(input string name);
        $display("test %s ended", name);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog sized well above the expected run length.
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        n_mismatch++;
        conclude();
    end

    // Main sequence.
    initial
    begin
        repeat (20) @(negedge sys_clk);
        check(mic_return_switch_oe_n, 1'b1);
        check(rate_fault, 2'h3);
        check(interrupt_output, 1'b0);
        rst = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            audio_ctrl = audio_ctrl_t'(rnd());
            if (i < 2)
                audio_ctrl.atten = i ? 5'h1f : 5'h08;
            telecom_ctrl = tel_ctrl_t'(rnd());
            audio_gain = 5'(rnd());
            offset_cancel_disable = audio_gain < 5'h10 || rnd() % 2 != 0;
            repeat (2) @(negedge sys_clk);
            check(speaker_drive_enable, audio_ctrl.playback_en);
            check(capture_path_on, audio_ctrl.capture_en);
            check(mic_return_switch_oe_n, !audio_ctrl.capture_en);
            check(mic_return_switch_out, 1'b0);
            check(analog_atten_step, analog_exp(audio_ctrl.atten));
            check(mic_gain_step, audio_gain);
            check(offset_cancel_enable, !offset_cancel_disable);
            check(voice_filter_on, telecom_ctrl.voiceband_filter_enable);
            check(line_drive_enable, 1'b1);
        end
        done("controls");
        measure(8, 16);
        measure(9, 17);
        measure(8 + int'(rnd() % 8), 16 + int'(rnd() % 8));
        done("rates");
        audio_rate_divisor = 7'h07;
        telecom_rate_divisor = 7'h0f;
        stream_on = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(rate_fault, 2'h3);
        count_ev(0, 300, n);
        check(16'(n), 16'h0000);
        check(play_ready, 1'b0);
        audio_rate_divisor = 7'h08;
        telecom_rate_divisor = 7'h10;
        wait_ev(0, t0);
        @(negedge sys_clk);
        check(play_ready, 1'b1);
        check(rate_fault, 2'h0);
        done("faults and buffer");
        audio_ctrl = '0;
        audio_ctrl.capture_en = 1'b1;
        audio_ctrl.playback_en = 1'b1;
        audio_ctrl.loopback = 1'b1;
        mic_sample = ~word;
        slow = 1'b1;
        for (int a = 0; a < 3; a++)
        begin
            audio_ctrl.atten = 5'(a * 8);
            repeat (3) wait_ev(2, t0);
            check(audio_cap_data, atten_exp(word, audio_ctrl.atten));
        end
        telecom_ctrl = '0;
        telecom_ctrl.loopback = 1'b1;
        tel_play_data = 16'h1234;
        line_sample = 16'h5678;
        repeat (3) wait_ev(3, t0);
        check(tel_cap_data, 16'h1234);
        audio_ctrl.loopback = 1'b0;
        telecom_ctrl.loopback = 1'b0;
        mic_sample = 16'(rnd());
        line_sample = 16'(rnd());
        repeat (2) wait_ev(2, t0);
        check(audio_cap_data, mic_sample);
        repeat (2) wait_ev(3, t0);
        check(tel_cap_data, line_sample);
        audio_ctrl.capture_en = 1'b0;
        count_ev(2, 1100, n);
        check(16'(n), 16'h0000);
        done("capture and loopback");
        audio_ctrl.mute = 1'b1;
        telecom_ctrl.line_output_silence = 1'b1;
        tel_play_data = 16'h4000;
        // Let a code launched before the mute drain out over a few oversampling ticks.
        repeat (40) @(negedge sys_clk);
        count_ev(5, 1100, n);
        check(16'(n), 16'h0000);
        count_ev(6, 1100, n);
        check(16'(n), 16'h0000);
        check(speaker_drive_enable, 1'b1);
        check(line_drive_enable, 1'b1);
        audio_ctrl.mute = 1'b0;
        audio_ctrl.atten = 5'h00;
        count_ev(5, 1100, n);
        check(n != 0, 1'b1);
        done("mute");
        for (int k = 0; k < 4; k++)
        begin
            overload_rise_irq_enable = k[0];
            overload_fall_irq_enable = k[1];
            clip_detect = 1'b1;
            count_ev(4, 8, n);
            check(16'(n), 16'(k[0]));
            check(audio_overload_flag, 1'b1);
            clip_detect = 1'b0;
            count_ev(4, 8, n);
            check(16'(n), 16'(k[1]));
            check(audio_overload_flag, 1'b0);
        end
        done("clip");
        conclude();
    end
endmodule // test_codec_rate_and_path_control
